/* File: design/cwgsc_consts.vh */
// Purpose: Constants for the waveform generator steering and shutdown block
// Assumes: Word-aligned 32-bit registers on a classic Wishbone slave
// Notes:   Offsets are byte addresses
`ifndef CWGSC_CONSTS_VH
`define CWGSC_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CWGSC_OFF_MAIN      8'h00
`define CWGSC_OFF_POL       8'h04
`define CWGSC_OFF_DBR       8'h08
`define CWGSC_OFF_DBF       8'h0C
`define CWGSC_OFF_SDCTL     8'h10
`define CWGSC_OFF_SDSRC     8'h14
`define CWGSC_OFF_STEER     8'h18
`define CWGSC_OFF_PINEN     8'h1C
`define CWGSC_OFF_CLKSEL    8'h20
`define CWGSC_OFF_INSEL     8'h24
`define CWGSC_OFF_IRQ_STAT  8'h28
`define CWGSC_OFF_IRQ_EN    8'h2C
`define CWGSC_OFF_IRQ_CLR   8'h30

// ----------------------------------------
// Fields and codes
// ----------------------------------------
`define CWGSC_SDSRC_ONES    8'h88
`define CWGSC_SDSRC_WMASK   8'h77
`define CWGSC_MODE_STEER    3'h0
`define CWGSC_MODE_SYNC     3'h1
`define CWGSC_INSEL_LAST    4'hA
`define CWGSC_SD_BIT        7
`define CWGSC_IRQ_W         2

`endif

/* File: design/cwgsc_top.v */
// Purpose: Steering, input select, clock select and auto-shutdown config
// Assumes: Inputs synchronous to clk_i; Wishbone classic slave, 1-cycle ack
// Notes:   Dead-band and bridge sequencing live outside this block
//
// Overview of operation
// - Timer postscale shutdown enables gate timer sources
// - Comparator and pin shutdown enables gate sources
// - Source enable bits 7 and 3 read one
// - Steered output carries waveform with polarity
// - Unsteered output carries its override data bit
// - Steering applies only in modes 000/001
// - Sync steering mode double-buffers steer enables
// - Four pin enable bits gate outputs A-D
// - Clock select: one fast osc, zero system
// - Input select codes 1011-1111 connect nothing
// - Unimplemented upper bits read back zero
// - Mode 000 steering, 001 synchronous steering
// - Polarity bit set inverts the waveform on that output, not its override data bit
// - Shutdown status reads one while shutdown active
`timescale 1ns/10ps
`include "cwgsc_consts.vh"

module cwgsc_top #(
   parameter DW = 32
) (
   // Clock, reset, enable
   input  wire          clk_i,
   input  wire          rst_i,
   input  wire          ce_i,
   // Wishbone classic slave
   input  wire          cyc_i,
   input  wire          stb_i,
   input  wire          we_i,
   input  wire [7:0]    adr_i,
   input  wire [3:0]    sel_i,
   input  wire [DW-1:0] dat_i,
   output reg  [DW-1:0] dat_o,
   output reg           ack_o,
   // Generator sources
   input  wire          generator_input_pin_i,
   input  wire          comparator1_synced_i,
   input  wire          comparator2_synced_i,
   input  wire          capture_compare1_output_i,
   input  wire          capture_compare2_output_i,
   input  wire [3:0]    logic_cell_output_i,
   input  wire          pulse_mod3_output_i,
   input  wire          pulse_mod4_output_i,
   // Shutdown timer sources
   input  wire          timer2_post_i,
   input  wire          timer4_post_i,
   input  wire          timer6_post_i,
   // Waveform from the dead-band stage and its rising edge marker
   input  wire          generator_waveform_i,
   input  wire          input_rise_i,
   // Outputs A..D, pin drive enables, selected input and register outputs
   output reg  [3:0]    out_o,
   output reg  [3:0]    out_oe_o,
   output wire          selected_input_o,
   output wire          clk_fast_sel_o,
   output wire [2:0]    mode_o,
   output wire          gen_enable_o,
   output wire [5:0]    rise_deadband_o,
   output wire [5:0]    fall_deadband_o,
   output wire          irq_o
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Register map, low byte of each word:
   //   00 main: enable b7, load b6, mode 2:0
   //   04 polarity 3:0, selected input level b5 (read only)
   //   08/0C rising/falling dead-band 5:0, passed straight out
   //   10 shutdown: status b7, restart b6, B/D state 5:4, A/C state 3:2
   //   14 shutdown source enables; b7 and b3 always read one
   //   18 steering: override data 7:4, steer enables 3:0
   //   1C pin enables 3:0
   //   20 clock select b0
   //   24 input select 3:0
   //   28 interrupt status, read only
   //   2C interrupt enable
   //   30 interrupt clear, write one to clear, reads zero
   //   Unlisted words read zero and ignore writes
   reg [7:0] main_q;
   reg [3:0] pol_q;
   reg [5:0] dbr_q;
   reg [5:0] dbf_q;
   reg [6:0] sdctl_q;
   reg       shutdown_q;
   reg [7:0] sdsrc_q;
   reg [3:0] ovr_q;
   reg [3:0] steer_wr_q;
   reg [3:0] steer_act_q;
   reg [3:0] pinen_q;
   reg       clksel_q;
   reg [3:0] insel_q;
   reg [`CWGSC_IRQ_W-1:0] irq_stat_q;
   reg [`CWGSC_IRQ_W-1:0] irq_en_q;
   reg       sd_seen_q;

   // Bus decode and per-register write strobes
   wire       wr_en;
   wire       wr_main;
   wire       wr_sdctl;
   wire       wr_steer;
   wire       wr_irq_clr;
   wire [2:0] mode;
   wire       steer_mode;
   wire       sync_mode;
   reg        in_sel;
   wire       sd_src;
   reg [DW-1:0] rd_d;
   wire [`CWGSC_IRQ_W-1:0] irq_ev;
   wire       sd_rise;
   wire [`CWGSC_IRQ_W-1:0] irq_clr;

   // A write lands at the edge that takes the request; ack rises at that same edge
   assign wr_en      = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
   assign wr_main    = wr_en & (adr_i == `CWGSC_OFF_MAIN);
   assign wr_sdctl   = wr_en & (adr_i == `CWGSC_OFF_SDCTL);
   assign wr_steer   = wr_en & (adr_i == `CWGSC_OFF_STEER);
   assign wr_irq_clr = wr_en & (adr_i == `CWGSC_OFF_IRQ_CLR);
   assign irq_clr    = wr_irq_clr ? dat_i[`CWGSC_IRQ_W-1:0] : {`CWGSC_IRQ_W{1'b0}};

   // Mode decode; modes 000 and 001 are the two steering modes
   assign mode       = main_q[2:0];
   assign steer_mode = (mode[2:1] == 2'b00);
   assign sync_mode  = (mode == `CWGSC_MODE_SYNC);

   // Input source selection. Reserved codes select a constant low so a stale
   // or mistyped code can never feed a live source into the generator; the
   // sources are already synchronous, so the mux adds no register stage.
   always @* begin
      case (insel_q)
         4'h0: in_sel = generator_input_pin_i;
         4'h1: in_sel = comparator1_synced_i;
         4'h2: in_sel = comparator2_synced_i;
         4'h3: in_sel = capture_compare1_output_i;
         4'h4: in_sel = capture_compare2_output_i;
         4'h5: in_sel = logic_cell_output_i[0];
         4'h6: in_sel = logic_cell_output_i[1];
         4'h7: in_sel = logic_cell_output_i[2];
         4'h8: in_sel = logic_cell_output_i[3];
         4'h9: in_sel = pulse_mod3_output_i;
         4'hA: in_sel = pulse_mod4_output_i;
         default: in_sel = 1'b0;
      endcase
   end
   assign selected_input_o = in_sel;

   // ----------------------------------------
   // Auto-shutdown source gating
   // ----------------------------------------
   // Each source passes only while its enable bit is set; bits 7 and 3 are
   // never looked at, so a stray one there cannot arm a phantom source
   wire sd_tmr6;
   wire sd_tmr4;
   wire sd_tmr2;
   wire sd_cmp2;
   wire sd_cmp1;
   wire sd_pin;

   assign sd_tmr6 = sdsrc_q[6] & timer6_post_i;
   assign sd_tmr4 = sdsrc_q[5] & timer4_post_i;
   assign sd_tmr2 = sdsrc_q[4] & timer2_post_i;
   assign sd_cmp2 = sdsrc_q[2] & comparator2_synced_i;
   assign sd_cmp1 = sdsrc_q[1] & comparator1_synced_i;
   assign sd_pin  = sdsrc_q[0] & generator_input_pin_i;
   // Sources are levels; any one of them holds the block in shutdown
   assign sd_src  = sd_tmr6 | sd_tmr4 | sd_tmr2 | sd_cmp2 | sd_cmp1 | sd_pin;

   // Interrupt events: shutdown onset, and a steering load in sync mode
   assign sd_rise = (sd_src | shutdown_q) & ~sd_seen_q;
   assign irq_ev  = {input_rise_i & sync_mode, sd_rise};

   // ----------------------------------------
   // Register writes and hardware updates
   // ----------------------------------------
   // Shutdown set wins over a software clear in the same cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         main_q      <= 8'h00;
         pol_q       <= 4'h0;
         dbr_q       <= 6'h00;
         dbf_q       <= 6'h00;
         sdctl_q     <= 7'h14;
         shutdown_q  <= 1'b0;
         sdsrc_q     <= 8'h00;
         ovr_q       <= 4'h0;
         steer_wr_q  <= 4'h0;
         steer_act_q <= 4'h0;
         pinen_q     <= 4'h0;
         clksel_q    <= 1'b0;
         insel_q     <= 4'h0;
         irq_stat_q  <= {`CWGSC_IRQ_W{1'b0}};
         irq_en_q    <= {`CWGSC_IRQ_W{1'b0}};
         sd_seen_q   <= 1'b0;
      end else if (ce_i) begin
         sd_seen_q <= sd_src | shutdown_q;
         if (wr_en) begin
            case (adr_i)
               // Load request only takes if the block was already enabled
               `CWGSC_OFF_MAIN:   main_q   <= {dat_i[7], dat_i[6] & main_q[7],
                                               3'h0, dat_i[2:0]};
               `CWGSC_OFF_POL:    pol_q    <= dat_i[3:0];
               `CWGSC_OFF_DBR:    dbr_q    <= dat_i[5:0];
               `CWGSC_OFF_DBF:    dbf_q    <= dat_i[5:0];
               `CWGSC_OFF_SDCTL:  sdctl_q  <= {dat_i[6:2], 2'b00};
               `CWGSC_OFF_SDSRC:  sdsrc_q  <= dat_i[7:0] & `CWGSC_SDSRC_WMASK;
               `CWGSC_OFF_STEER:  begin
                  ovr_q      <= dat_i[7:4];
                  steer_wr_q <= dat_i[3:0];
               end
               `CWGSC_OFF_PINEN:  pinen_q  <= dat_i[3:0];
               `CWGSC_OFF_CLKSEL: clksel_q <= dat_i[0];
               `CWGSC_OFF_INSEL:  insel_q  <= dat_i[3:0];
               `CWGSC_OFF_IRQ_EN: irq_en_q <= dat_i[`CWGSC_IRQ_W-1:0];
               default: ;
            endcase
         end
         // Status: an asserted source wins; a software write lands only when idle
         if (sd_src)
            shutdown_q <= 1'b1;
         else if (wr_sdctl)
            shutdown_q <= dat_i[`CWGSC_SD_BIT];
         // Sync mode loads steering on input rising edge; else immediate
         if (sync_mode) begin
            if (input_rise_i)
               steer_act_q <= steer_wr_q;
         end else begin
            steer_act_q <= wr_steer ? dat_i[3:0] : steer_wr_q;
         end
         // Load request bit clears once the buffers are taken
         if (input_rise_i && !wr_main)
            main_q[6] <= 1'b0;
         // Interrupt status, set wins over clear
         irq_stat_q <= irq_ev | (irq_stat_q & ~irq_clr);
      end
   end

   // ----------------------------------------
   // Read mux and acknowledge
   // ----------------------------------------
   // Read data is decoded from the address every cycle; any bit a register
   // does not implement stays at the zero given at the top of the process
   always @* begin
      rd_d = {DW{1'b0}};
      case (adr_i)
         `CWGSC_OFF_MAIN:     rd_d[7:0] = main_q;
         `CWGSC_OFF_POL:      rd_d[7:0] = {2'b00, in_sel, 1'b0, pol_q};
         `CWGSC_OFF_DBR:      rd_d[5:0] = dbr_q;
         `CWGSC_OFF_DBF:      rd_d[5:0] = dbf_q;
         `CWGSC_OFF_SDCTL:    rd_d[7:0] = {shutdown_q, sdctl_q[6:2], 2'b00};
         `CWGSC_OFF_SDSRC:    rd_d[7:0] = sdsrc_q | `CWGSC_SDSRC_ONES;
         `CWGSC_OFF_STEER:    rd_d[7:0] = {ovr_q, steer_wr_q};
         `CWGSC_OFF_PINEN:    rd_d[3:0] = pinen_q;
         `CWGSC_OFF_CLKSEL:   rd_d[0]   = clksel_q;
         `CWGSC_OFF_INSEL:    rd_d[3:0] = insel_q;
         `CWGSC_OFF_IRQ_STAT: rd_d[`CWGSC_IRQ_W-1:0] = irq_stat_q;
         `CWGSC_OFF_IRQ_EN:   rd_d[`CWGSC_IRQ_W-1:0] = irq_en_q;
         default:             rd_d = {DW{1'b0}};
      endcase
   end

   // Single-cycle ack; unmapped addresses ack with zero data. Read data is
   // registered with the ack so it stands for exactly the cycle the master
   // samples it; back-to-back requests are taken every other cycle, as none is taken while ack is high.
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= {DW{1'b0}};
      end else if (ce_i) begin
         ack_o <= cyc_i & stb_i & ~ack_o;
         dat_o <= rd_d;
      end
   end

   // ----------------------------------------
   // Output steering per channel
   // ----------------------------------------
   // Channels A/C use one shutdown field, B/D the other. Each channel works
   // out its next level and drive enable here; a single process below
   // registers all four so that each output vector has exactly one driver.
   wire [3:0] val_d;
   wire [3:0] drv_d;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_ch
         wire [1:0] sd_fld;
         wire       wave;
         reg        val;
         reg        drv;
         assign sd_fld = (g % 2 == 0) ? sdctl_q[3:2] : sdctl_q[5:4];
         assign wave   = generator_waveform_i ^ pol_q[g];
         // Steering first, then the shutdown state overrides it
         always @* begin
            val = wave;
            drv = pinen_q[g];
            if (steer_mode)
               val = steer_act_q[g] ? wave : ovr_q[g];
            if (shutdown_q) begin
               case (sd_fld)
                  2'b11:   val = 1'b1;
                  2'b10:   val = 1'b0;
                  2'b01:   drv = 1'b0; // Pin released while shut down
                  default: val = pol_q[g]; // Inactive level with polarity
               endcase
            end
         end
         assign val_d[g] = val;
         assign drv_d[g] = drv;
      end
   endgenerate

   // Outputs are registered: a pin never glitches on a mid-cycle source
   // change, at the cost of one clock of latency from any input or register
   always @(posedge clk_i) begin
      if (rst_i) begin
         out_o    <= 4'h0;
         out_oe_o <= 4'h0;
      end else if (ce_i) begin
         out_o    <= val_d;
         out_oe_o <= drv_d;
      end
   end

   // Plain register outputs. The clock mux itself sits with the oscillators;
   // only the choice is held here, so switching clocks without a glitch is
   // the job of whoever owns that mux.
   assign clk_fast_sel_o  = clksel_q;
   assign mode_o          = mode;
   assign gen_enable_o    = main_q[7];
   assign rise_deadband_o = dbr_q;
   assign fall_deadband_o = dbf_q;
   assign irq_o           = |(irq_stat_q & irq_en_q);

endmodule // cwgsc_top

/* File: dv/cwgsc_partner.sv */
// Purpose: Far-side model of the sources, timers and waveform
// Assumes: Bench requests land one edge later, as on-chip outputs would
// Notes:   Rise marker pulses once per rising edge of the waveform
`timescale 1ns/10ps
module cwgsc_partner (
   // Clock, reset, bench request
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire [14:0] req_i,
   // Levels {wave, timers, sources} and rise marker
   output reg  [14:0] lvl_o,
   output reg         rise_o
);
   // Registered so no level moves on the block's sampling edge
   always @(posedge clk_i) begin
      lvl_o  <= rst_i ? 15'h0000 : req_i;
      rise_o <= ~rst_i & req_i[14] & ~lvl_o[14];
   end
endmodule // cwgsc_partner

/* File: dv/cwgsc_checker.sv */
// Purpose: Port assertions for the steering and shutdown block
// Assumes: Clock enable high while bus traffic runs
// Notes:   A register write shows on its output from the edge of its ack
`timescale 1ns/10ps
module cwgsc_checker #(
   parameter DW = 32
) (
   // Clock, reset, bus
   input wire          clk_i,
   input wire          rst_i,
   input wire          ce_i,
   input wire          cyc_i,
   input wire          stb_i,
   input wire          we_i,
   input wire [7:0]    adr_i,
   input wire [DW-1:0] dat_i,
   input wire [DW-1:0] dat_o,
   input wire          ack_o,
   // Block outputs
   input wire [3:0]    out_o,
   input wire [3:0]    out_oe_o,
   input wire          clk_fast_sel_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Request taken at this edge, and its read form
   wire tk = cyc_i && stb_i && ce_i && !ack_o;
   wire rd = tk && !we_i;
   property p_ack_due; tk |=> ack_o; endproperty
   a_ack_due: assert property (p_ack_due) else $error("ack late");
   property p_ack_one; ack_o && ce_i |=> !ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack held");
   property p_ack_why; ack_o |-> $past(tk); endproperty
   a_ack_why: assert property (p_ack_why) else $error("ack unasked");
   property p_rst; $fell(rst_i) |-> out_o == 4'h0 && out_oe_o == 4'h0; endproperty
   a_rst: assert property (p_rst) else $error("outputs live after reset");
   property p_ones; rd && adr_i == 8'h14 |=> dat_o[7] && dat_o[3]; endproperty
   a_ones: assert property (p_ones) else $error("fixed one bits");
   property p_hi; ack_o |-> dat_o[DW-1:8] == 0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits");
   property p_nib; rd && adr_i[7:4] == 4'h2 |=> dat_o[7:4] == 4'h0; endproperty
   a_nib: assert property (p_nib) else $error("unused read bits");
   // Clock choice follows the written bit from the next edge on
   property p_cs;
      tk && we_i && adr_i == 8'h20 |=> clk_fast_sel_o == $past(dat_i[0]);
   endproperty
   a_cs: assert property (p_cs) else $error("clock select");
endmodule // cwgsc_checker
bind cwgsc_top cwgsc_checker #(.DW(DW)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .out_o(out_o), .out_oe_o(out_oe_o), .clk_fast_sel_o(clk_fast_sel_o));

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the steering and shutdown block
// Assumes: Clock enable and byte selects held high
// Notes:   Bus waits are open; a hang ends through the watchdog
`timescale 1ns/10ps
module testbench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [7:0]  wd = 8'h00;
   logic [14:0] req = 15'h0000;
   wire  [31:0] rdat;
   wire  [14:0] far;
   wire  [3:0]  out, oe;
   wire         ack, rise, si, fs, irq;
   integer      err_total = 0;
   integer      num_checks = 0;
   integer      k, b;
   cwgsc_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(cyc),
      .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i({24'h000000, wd}), .dat_o(rdat),
      .ack_o(ack), .generator_input_pin_i(far[0]), .comparator1_synced_i(far[1]),
      .comparator2_synced_i(far[2]), .capture_compare1_output_i(far[3]),
      .capture_compare2_output_i(far[4]), .logic_cell_output_i(far[8:5]),
      .pulse_mod3_output_i(far[9]), .pulse_mod4_output_i(far[10]), .timer2_post_i(far[11]),
      .timer4_post_i(far[12]), .timer6_post_i(far[13]), .generator_waveform_i(far[14]),
      .input_rise_i(rise), .out_o(out), .out_oe_o(oe), .selected_input_o(si),
      .clk_fast_sel_o(fs), .mode_o(), .gen_enable_o(), .rise_deadband_o(),
      .fall_deadband_o(), .irq_o(irq));
   cwgsc_partner u_far (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .lvl_o(far), .rise_o(rise));
   task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // One classic cycle held until ack is sampled; a read compares with d
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= w ? d : 8'h00;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      cyc <= 1'b0;
      if (!w) ck($sformatf("reg %h", a), d, rdat[7:0]);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask
   // Outputs settle a few edges after a level change
   task automatic po(input logic [7:0] e);
      repeat (5) @(posedge clk_i);
      ck("out", e, {4'h0, out});
   endtask
   task automatic t_regs;
      wb(1'b0, 8'h14, 8'h88);
      wb(1'b0, 8'h18, 8'h00);
      wb(1'b0, 8'h24, 8'h00);
      wr(8'h14, 8'hFF);
      wb(1'b0, 8'h14, 8'hFF);
      wr(8'h20, 8'hFF);
      wb(1'b0, 8'h20, 8'h01);
      ck("clk_fast_sel", 8'h01, {7'h00, fs});
      wr(8'hFC, 8'hFF);
      wb(1'b0, 8'hFC, 8'h00);
      wr(8'h14, 8'h00);
      wr(8'h20, 8'h00);
   endtask
   // Each code with every other source at the opposite level
   task automatic t_insel;
      for (k = 0; k < 16; k++) begin
         wr(8'h24, k[7:0]);
         req <= (k < 11) ? 15'h07FF ^ (15'h0001 << k) : 15'h07FF;
         repeat (3) @(posedge clk_i);
         ck("selected", 8'h00, {7'h00, si});
         req <= (k < 11) ? 15'h0001 << k : 15'h07FF;
         repeat (3) @(posedge clk_i);
         ck("selected", {7'h00, k < 11}, {7'h00, si});
      end
   endtask
   task automatic t_steer;
      wr(8'h00, 8'h80);
      wr(8'h04, 8'h08);
      wr(8'h1C, 8'h05);
      wr(8'h18, 8'h5A);
      req <= 15'h4000;
      po(8'h07);
      ck("pin_enable", 8'h05, {4'h0, oe});
      req <= 15'h0000;
      po(8'h0D);
   endtask
   // New steer enables must wait for a rising input
   task automatic t_sync;
      wr(8'h18, 8'h00);
      wr(8'h04, 8'h00);
      wr(8'h00, 8'h81);
      req <= 15'h4000;
      repeat (4) @(posedge clk_i);
      wr(8'h18, 8'h0F);
      wb(1'b0, 8'h18, 8'h0F);
      po(8'h00);
      req <= 15'h0000;
      repeat (2) @(posedge clk_i);
      req <= 15'h4000;
      po(8'h0F);
   endtask
   // Each source alone: blocked, then enabled, then cleared with its irq
   task automatic t_shut;
      wr(8'h00, 8'h80);
      wr(8'h10, 8'h3C);
      wr(8'h2C, 8'h01);
      for (k = 0; k < 6; k++) begin
         b = (k < 3) ? k : k + 1;
         wr(8'h14, 8'h77 ^ (8'h01 << b));
         req <= (b < 3) ? 15'h0001 << b : 15'h0001 << (b + 7);
         po(8'h00);
         wr(8'h14, 8'h01 << b);
         po(8'h0F);
         wb(1'b0, 8'h10, 8'hBC);
         ck("irq", 8'h01, {7'h00, irq});
         req <= 15'h0000;
         repeat (3) @(posedge clk_i);
         wr(8'h10, 8'h3C);
         wr(8'h30, 8'h01);
         wb(1'b0, 8'h10, 8'h3C);
         ck("irq", 8'h00, {7'h00, irq});
         req <= 15'h4000;
         repeat (3) @(posedge clk_i);
      end
      wr(8'h2C, 8'h00);
      wr(8'h14, 8'h01);
      req <= 15'h0001;
      po(8'h0F);
      ck("irq", 8'h00, {7'h00, irq});
      // Source still asserted: state 01 releases pins, 00 shows polarity
      wr(8'h10, 8'h14);
      repeat (3) @(posedge clk_i);
      ck("pin_enable", 8'h00, {4'h0, oe});
      wr(8'h10, 8'h00);
      wr(8'h04, 8'h05);
      po(8'h05);
   endtask
   task automatic summarize;
      if (err_total == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial forever #4 clk_i = ~clk_i;
   // Watchdog well beyond the expected run
   initial begin
      #200000;
      err_total++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_insel();
      t_steer();
      t_sync();
      t_shut();
      summarize();
   end
endmodule // testbench
